/* hw/piopo_top.sv */
// Purpose: parallel I/O controller register bank, pin ownership and direction
// Assumes: APB slave, single clock, pins synchronous to i_clk_sys
// Notes:   zero wait states; pready is always high
// Operation
// [RULE1] Bank decoded at fixed base, word offsets
// [RULE2] Owner enable write hands pins to controller
// [RULE3] Controller-owned pins zero the peripheral input
// [RULE4] Owner disable write returns pins to peripheral
// [RULE5] Owner status reads ownership, resets 0x01FFFFFF
// [RULE6] Drive set write enables output driver
// [RULE7] Drive clear write disables output driver
// [RULE8] Direction stored even while peripheral owns
// [RULE9] Drive status reads direction, resets zero
// [RULE10] Stored direction applies only when controller owns
// [RULE11] Pin level register shows live pin levels
// [RULE12] Change flags zero at reset, catch later changes
// [RULE13] Unmuxed lines stay controller-owned always
// [RULE14] 32-bit registers, undefined bits ignored, read zero
// [RULE15] Any change sets flag; reading clears all
// [RULE16] Write-only and reserved offsets read zero
`timescale 1ns/100ps
module piopo_top
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_rstn,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [31:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic [31:0] i_pin_in,
	output logic      [31:0] o_pin_out,
	output logic      [31:0] o_pin_oe,
	input  wire logic [31:0] i_periph_out,
	input  wire logic [31:0] i_periph_oe,
	output logic      [31:0] o_periph_in,
	output logic      [31:0] o_owner,
	output logic      [31:0] o_filter_sel,
	output logic             o_irq
);
	import piopo_pkg::*;

	typedef struct packed
	{
		logic [31:0] owner;
		logic [31:0] drv;
		logic [31:0] filt;
		logic [31:0] outv;
		logic [31:0] mask;
		logic [31:0] flags;
		logic [31:0] rdata;
	} piopo_state_t;

	piopo_state_t s_q;
	piopo_state_t s_d;

	piopo_chg_if chg ();

	piopo_chg_det u_det
	(
		.i_clk_sys (i_clk_sys),
		.i_rstn    (i_rstn),
		.i_pin_in  (i_pin_in),
		.chg       (chg)
	);

	function automatic logic [31:0] set_clr(input logic [31:0] cur,
		input logic [31:0] set, input logic [31:0] clr);
		set_clr = (cur | set) & ~clr;
	endfunction

	logic        hit;
	logic        wr;
	logic        rd;
	logic [7:0]  off;
	logic [31:0] wd;
	logic [31:0] rmux;

	assign hit = i_psel && (i_paddr[31:8] == PIOPO_BASE[31:8]) && (i_paddr[1:0] == 2'h0); // [RULE1]
	assign off = i_paddr[7:0];
	assign wr  = hit && i_penable && i_pwrite;
	assign rd  = hit && i_penable && !i_pwrite;
	assign wd  = i_pwdata & DEFINED_LINES; // [RULE14]

	always_comb
	begin
		case (off)
			OFF_OWNER_STAT: rmux = s_q.owner; // [RULE5]
			OFF_DRV_STAT:   rmux = s_q.drv; // [RULE9]
			OFF_FILT_STAT:  rmux = s_q.filt;
			OFF_OUT_STAT:   rmux = s_q.outv;
			OFF_PIN_LEVEL:  rmux = chg.level; // [RULE11]
			OFF_IRQ_MASK:   rmux = s_q.mask;
			OFF_CHG_FLAGS:  rmux = s_q.flags | chg.change; // [RULE12]
			default:        rmux = 32'h00000000; // [RULE16]
		endcase
	end

	always_comb
	begin
		s_d = s_q;
		if (wr)
		begin
			case (off)
				OFF_OWNER_EN:  s_d.owner = s_q.owner | (wd & MUXED_LINES); // [RULE2] [RULE13]
				OFF_OWNER_DIS: s_d.owner = s_q.owner & ~(wd & MUXED_LINES); // [RULE4] [RULE13]
				OFF_DRV_SET:   s_d.drv   = s_q.drv | wd; // [RULE6] [RULE8]
				OFF_DRV_CLR:   s_d.drv   = s_q.drv & ~wd; // [RULE7] [RULE8]
				OFF_FILT_ON:   s_d.filt  = set_clr(s_q.filt, wd, 32'h00000000);
				OFF_FILT_OFF:  s_d.filt  = set_clr(s_q.filt, 32'h00000000, wd);
				OFF_OUT_SET:   s_d.outv  = set_clr(s_q.outv, wd, 32'h00000000);
				OFF_OUT_CLR:   s_d.outv  = set_clr(s_q.outv, 32'h00000000, wd);
				OFF_IRQ_EN:    s_d.mask  = set_clr(s_q.mask, wd, 32'h00000000);
				OFF_IRQ_DIS:   s_d.mask  = set_clr(s_q.mask, 32'h00000000, wd);
				default:       s_d.owner = s_q.owner; // [RULE16]
			endcase
		end
		// Read clears; a change in the same cycle is cleared too, as it is returned now
		if (rd && off == OFF_CHG_FLAGS)
			s_d.flags = 32'h00000000; // [RULE15]
		else
			s_d.flags = s_q.flags | chg.change; // [RULE15]
		if (rd)
			s_d.rdata = rmux;
		else
			s_d.rdata = 32'h00000000;
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			s_q.owner <= RST_OWNER_STAT; // [RULE5]
			s_q.drv   <= RST_DRV_STAT; // [RULE9]
			s_q.filt  <= RST_FILT_STAT;
			s_q.outv  <= RST_OUT_STAT;
			s_q.mask  <= RST_IRQ_MASK;
			s_q.flags <= RST_CHG_FLAGS; // [RULE12]
			s_q.rdata <= 32'h00000000;
		end
		else
			s_q <= s_d;
	end

	assign o_pready     = 1'b1;
	assign o_pslverr    = 1'b0;
	assign o_prdata     = rmux;
	assign o_owner      = s_q.owner;
	assign o_filter_sel = s_q.filt;
	assign o_periph_in  = i_pin_in & ~s_q.owner; // [RULE3]
	assign o_pin_oe     = (s_q.owner & s_q.drv) | (~s_q.owner & i_periph_oe); // [RULE10]
	assign o_pin_out    = (s_q.owner & s_q.outv) | (~s_q.owner & i_periph_out);
	assign o_irq        = |(s_q.flags & s_q.mask);

	sequence s_owner_en_wr;
		wr && off == OFF_OWNER_EN;
	endsequence

	sequence s_owner_dis_wr;
		wr && off == OFF_OWNER_DIS;
	endsequence

	a_owner_enable: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		s_owner_en_wr |=> ((o_owner & ($past(wd) & MUXED_LINES)) == ($past(wd) & MUXED_LINES)))
		else $error("owner enable write not applied"); // [RULE2]

	a_owner_disable: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		s_owner_dis_wr |=> ((o_owner & $past(wd) & MUXED_LINES) == 32'h00000000))
		else $error("owner disable write not applied"); // [RULE4]

	a_plain_owned: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(o_owner & ~MUXED_LINES) == ~MUXED_LINES)
		else $error("plain line lost controller ownership"); // [RULE13]

	a_periph_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(o_periph_in & o_owner) == 32'h00000000)
		else $error("peripheral input not forced low"); // [RULE3]

	a_dir_apply: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		((o_pin_oe ^ s_q.drv) & o_owner) == 32'h00000000
		&& ((o_pin_oe ^ i_periph_oe) & ~o_owner) == 32'h00000000)
		else $error("pin direction source wrong"); // [RULE10]

	a_drv_set: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		wr && off == OFF_DRV_SET |=> (s_q.drv & $past(wd)) == $past(wd))
		else $error("drive set not recorded"); // [RULE6] [RULE8]

	a_drv_clr: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		wr && off == OFF_DRV_CLR |=> (s_q.drv & $past(wd)) == 32'h00000000)
		else $error("drive clear not recorded"); // [RULE7] [RULE8]

	a_flag_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		rd && off == OFF_CHG_FLAGS |=> s_q.flags == 32'h00000000)
		else $error("change flags not cleared by read"); // [RULE15]

	a_flag_set: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		!(rd && off == OFF_CHG_FLAGS) ##0 (chg.change != 32'h00000000)
		|=> (s_q.flags & $past(chg.change)) == $past(chg.change))
		else $error("level change lost"); // [RULE12] [RULE15]

	a_wo_read_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		rd && (off == OFF_OWNER_EN || off == OFF_DRV_SET || off == 8'h0C) |-> o_prdata == 32'h00000000)
		else $error("write-only or reserved read not zero"); // [RULE16]

	a_status_read: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		rd && off == OFF_OWNER_STAT |-> o_prdata == o_owner)
		else $error("owner status readback wrong"); // [RULE5]

	a_dir_read: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		rd && off == OFF_DRV_STAT |-> o_prdata == s_q.drv)
		else $error("drive status readback wrong"); // [RULE9]
endmodule // piopo_top

/* include/piopo_pkg.sv */
// Purpose: constants for the parallel I/O pin owner and direction block
// Assumes: APB slave, 32-bit data, byte addresses
// Notes:   offsets are byte offsets from the bank base
package piopo_pkg;
	localparam logic [31:0] PIOPO_BASE        = 32'hFFFF0000;
	localparam logic [7:0]  OFF_OWNER_EN      = 8'h00;
	localparam logic [7:0]  OFF_OWNER_DIS     = 8'h04;
	localparam logic [7:0]  OFF_OWNER_STAT    = 8'h08;
	localparam logic [7:0]  OFF_DRV_SET       = 8'h10;
	localparam logic [7:0]  OFF_DRV_CLR       = 8'h14;
	localparam logic [7:0]  OFF_DRV_STAT      = 8'h18;
	localparam logic [7:0]  OFF_FILT_ON       = 8'h20;
	localparam logic [7:0]  OFF_FILT_OFF      = 8'h24;
	localparam logic [7:0]  OFF_FILT_STAT     = 8'h28;
	localparam logic [7:0]  OFF_OUT_SET       = 8'h30;
	localparam logic [7:0]  OFF_OUT_CLR       = 8'h34;
	localparam logic [7:0]  OFF_OUT_STAT      = 8'h38;
	localparam logic [7:0]  OFF_PIN_LEVEL     = 8'h3C;
	localparam logic [7:0]  OFF_IRQ_EN        = 8'h40;
	localparam logic [7:0]  OFF_IRQ_DIS       = 8'h44;
	localparam logic [7:0]  OFF_IRQ_MASK      = 8'h48;
	localparam logic [7:0]  OFF_CHG_FLAGS     = 8'h4C;
	localparam logic [31:0] RST_OWNER_STAT    = 32'h01FFFFFF;
	localparam logic [31:0] RST_DRV_STAT      = 32'h00000000;
	localparam logic [31:0] RST_FILT_STAT     = 32'h00000000;
	localparam logic [31:0] RST_OUT_STAT      = 32'h00000000;
	localparam logic [31:0] RST_IRQ_MASK      = 32'h00000000;
	localparam logic [31:0] RST_CHG_FLAGS     = 32'h00000000;
	// Lines with a peripheral behind them; others are plain I/O
	localparam logic [31:0] MUXED_LINES       = 32'hFE70FFFF;
	localparam logic [31:0] DEFINED_LINES     = 32'hFFFFFFFF;
	localparam int          PIOPO_WIDTH       = 32;
endpackage

/* include/piopo_chg_if.sv */
// Purpose: carries pin levels and change events between modules
// Assumes: one clock domain
// Notes:   levels are sampled, change is one-cycle per bit
`timescale 1ns/100ps
interface piopo_chg_if;
	logic [31:0] level;
	logic [31:0] change;
	modport det (output level, output change);
	modport use_side (input level, input change);
endinterface

/* hw/piopo_chg_det.sv */
// Purpose: samples pin levels and flags level changes
// Assumes: pin inputs synchronous to i_clk_sys
// Notes:   first sample after reset arms the detector
`timescale 1ns/100ps
module piopo_chg_det
(
	input  wire logic  i_clk_sys,
	input  wire logic  i_rstn,
	input  wire logic [31:0] i_pin_in,
	piopo_chg_if.det   chg
);
	import piopo_pkg::*;

	typedef struct packed
	{
		logic [31:0] lvl;
		logic        armed;
	} piopo_det_t;

	piopo_det_t s_q;
	piopo_det_t s_d;

	always_comb
	begin
		s_d       = s_q;
		s_d.lvl   = i_pin_in;
		s_d.armed = 1'b1;
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// Pin level readback and change after reset release [RULE11] [RULE12]
	assign chg.level  = s_q.lvl;
	assign chg.change = s_q.armed ? (s_q.lvl ^ i_pin_in) & DEFINED_LINES : 32'h00000000;
endmodule // piopo_chg_det

/* dv/piopo_pin_model.sv */
// Purpose: pins and peripherals around the I/O controller
// Assumes: pins settle well inside one clock
// Notes:   pins nobody drives take the level set by the bench
`timescale 1ns/100ps
module piopo_pin_model
(
	input  wire logic [31:0] i_pin_out,
	input  wire logic [31:0] i_pin_oe,
	input  wire logic [31:0] i_ext_level,
	output logic      [31:0] o_pin_in,
	output logic      [31:0] o_periph_out,
	output logic      [31:0] o_periph_oe
);
	assign o_periph_out = 32'h5A00C3F0;
	assign o_periph_oe  = 32'hF00000F0;
	// Driven pins follow their driver, the rest the outside level
	assign o_pin_in = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_level);
endmodule // piopo_pin_model

/* dv/piopo_tb.sv */
// Purpose: self-checking bench for the I/O controller register bank
// Assumes: APB answers within 20 cycles
// Notes:   expected values come from package constants, literal patterns and pin model signals
`timescale 1ns/100ps
module testbench;
	import piopo_pkg::*;
	logic        clk, rstn, psel, pen, pwr, rdy, irq;
	logic [31:0] addr, wdat, rdat, pin, pout, poe, pco, pce, pin_p, own, ext, rdv;
	int          errors, n_checks;
	piopo_top DUT
	(
		.i_clk_sys   (clk),
		.i_rstn      (rstn),
		.i_psel      (psel),
		.i_penable   (pen),
		.i_pwrite    (pwr),
		.i_paddr     (addr),
		.i_pwdata    (wdat),
		.o_prdata    (rdat),
		.o_pready    (rdy),
		.o_pslverr   (),
		.i_pin_in    (pin),
		.o_pin_out   (pout),
		.o_pin_oe    (poe),
		.i_periph_out(pco),
		.i_periph_oe (pce),
		.o_periph_in (pin_p),
		.o_owner     (own),
		.o_filter_sel(),
		.o_irq       (irq)
	);
	piopo_pin_model pins
	(
		.i_pin_out   (pout),
		.i_pin_oe    (poe),
		.i_ext_level (ext),
		.o_pin_in    (pin),
		.o_periph_out(pco),
		.o_periph_oe (pce)
	);
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
			errors++;
		end
	endtask
	task automatic complete_run;
		if (errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int   n;
		logic got;
		@(posedge clk);
		psel <= 1'b1;
		pen  <= 1'b0;
		pwr  <= w;
		addr <= a;
		wdat <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do
		begin
			// Settled answer, taken for the coming rising edge
			@(negedge clk);
			got = rdy;
			rdv = rdat;
			@(posedge clk);
			n++;
		end
		while (got !== 1'b1 && n < 20);
		if (got !== 1'b1)
		begin
			errors++;
			complete_run();
		end
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] o, input logic [31:0] d);
		apb(1'b1, {PIOPO_BASE[31:8], o}, d);
	endtask
	task automatic rc(input string nm, input logic [7:0] o, input logic [31:0] exp);
		apb(1'b0, {PIOPO_BASE[31:8], o}, 32'h0);
		chk(nm, rdv, exp);
	endtask
	task automatic do_reset;
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
	endtask
	task automatic sc_reset;
		logic [7:0] z [8] = '{OFF_OWNER_EN, OFF_OWNER_DIS, OFF_DRV_SET, OFF_DRV_CLR,
			OFF_IRQ_DIS, 8'h0C, 8'h1C, 8'h2C};
		rc("owner_rst", OFF_OWNER_STAT, RST_OWNER_STAT);
		chk("owner_port", own, RST_OWNER_STAT);
		rc("drv_rst", OFF_DRV_STAT, RST_DRV_STAT);
		rc("mask_rst", OFF_IRQ_MASK, RST_IRQ_MASK);
		rc("flags_rst", OFF_CHG_FLAGS, RST_CHG_FLAGS);
		rc("level_rst", OFF_PIN_LEVEL, pce & pco & 32'hFE000000);
		foreach (z[i]) rc("zero_read", z[i], 32'h0);
	endtask
	task automatic sc_owner;
		wr(OFF_OWNER_DIS, 32'hFFFFFFFF);
		rc("owner_dis", OFF_OWNER_STAT, ~MUXED_LINES);
		wr(OFF_OWNER_EN, 32'h00000003);
		wr(8'h0C, 32'hFFFFFFFF);
		apb(1'b1, 32'hFFFE0000, 32'hFFFFFFFF);
		rc("owner_en", OFF_OWNER_STAT, ~MUXED_LINES | 32'h3);
		chk("periph_in", pin_p, pin & MUXED_LINES & ~32'h3);
	endtask
	task automatic sc_dir;
		wr(OFF_DRV_SET, 32'h0000000F);
		rc("drv_set", OFF_DRV_STAT, 32'hF);
		wr(OFF_DRV_CLR, 32'h00000005);
		rc("drv_clr", OFF_DRV_STAT, 32'hA);
		chk("pin_oe", poe, 32'hF00000F2);
		chk("pin_out", pout, 32'h5A00C3F0);
		wr(OFF_OWNER_EN, 32'h00000008);
		#1;
		chk("pin_oe_own", poe, 32'hF00000FA);
	endtask
	task automatic sc_change;
		rc("flags_clr", OFF_CHG_FLAGS, 32'h000000F0);
		wr(OFF_IRQ_EN, 32'h00000100);
		rc("mask", OFF_IRQ_MASK, 32'h100);
		ext <= 32'h00010100;
		repeat (3) @(posedge clk);
		#1;
		chk("irq_on", {31'h0, irq}, 32'h1);
		apb(1'b0, {PIOPO_BASE[31:8], OFF_PIN_LEVEL}, 32'h0);
		chk("level", rdv & 32'h0001FF00, 32'h00010100);
		rc("flags", OFF_CHG_FLAGS, 32'h00010100);
		rc("flags_gone", OFF_CHG_FLAGS, 32'h0);
		#1;
		chk("irq_off", {31'h0, irq}, 32'h0);
		wr(OFF_IRQ_DIS, 32'h00000100);
		ext <= 32'h0;
		repeat (3) @(posedge clk);
		#1;
		chk("irq_masked", {31'h0, irq}, 32'h0);
		rc("flags_masked", OFF_CHG_FLAGS, 32'h00010100);
	endtask
	task automatic sc_rerst;
		do_reset();
		#1;
		chk("owner_rerst", own, RST_OWNER_STAT);
		@(posedge clk);
		ext <= 32'h00020000;
		repeat (3) @(posedge clk);
		rc("flags_first", OFF_CHG_FLAGS, 32'h00020000);
	endtask
	initial
	begin
		rstn = 1'b0;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		addr = 32'h0;
		wdat = 32'h0;
		ext = 32'h0;
		errors = 0;
		n_checks = 0;
		do_reset();
		sc_reset();
		sc_owner();
		sc_dir();
		sc_change();
		sc_rerst();
		complete_run();
	end
endmodule // testbench
